// [ppp_pkg_mem.sv]
// Shared constants for the parallel program port, and its storage array
`timescale 1ns/1ps
package ppp_pkg;
    localparam int CLK_PERIOD_NS = 20;
    localparam int PROG_TIME_NS = 2000;
    localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FLASH_AW = 12;
    localparam int EE_AW = 9;
    localparam logic [FLASH_AW-1:0] FLASH_LAST = 12'hfff;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [15:0] ERASED_WORD = 16'hffff;
    localparam logic [1:0] LOCK_RESET = 2'h3;
    localparam logic [7:0] FUSE_RESET = 8'hff;
    localparam int LOCK_LSB = 1;
    localparam logic [1:0] ACT_ADDR = 2'h0;
    localparam logic [1:0] ACT_DATA = 2'h1;
    localparam logic [1:0] ACT_CMD = 2'h2;
    localparam logic [1:0] ACT_IDLE = 2'h3;
    localparam logic [7:0] CMD_CHIP_ERASE = 8'h80;
    localparam logic [7:0] CMD_WR_FUSE = 8'h40;
    localparam logic [7:0] CMD_WR_LOCK = 8'h20;
    localparam logic [7:0] CMD_WR_FLASH = 8'h10;
    localparam logic [7:0] CMD_WR_EE = 8'h11;
    localparam logic [7:0] CMD_RD_SIG = 8'h08;
    localparam logic [7:0] CMD_RD_LOCKFUSE = 8'h04;
    localparam logic [7:0] CMD_RD_FLASH = 8'h02;
    localparam logic [7:0] CMD_RD_EE = 8'h03;
    // Identification bytes: values are arbitrary
    localparam logic [7:0] SIG_BYTE0 = 8'h5a;
    localparam logic [7:0] SIG_BYTE1 = 8'ha5;
    localparam logic [7:0] SIG_BYTE2 = 8'h3c;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ERASE = 3'b010,
        ST_PROG = 3'b100
    } ppp_state_t;
endpackage

module ppp_mem #(
    parameter int AW = 9,
    parameter int DW = 8
) (
    input wire logic i_mclk, // Clock
    input wire logic i_we, // Write enable
    input wire logic [AW-1:0] i_addr, // Shared address
    input wire logic [DW-1:0] i_wdata, // Write data
    output logic [DW-1:0] o_rdata // Registered read data
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge i_mclk) begin
        if (i_we) begin
            mem[i_addr] <= i_wdata;
        end
        o_rdata <= mem[i_addr];
    end
endmodule

// [ppp_port.sv]
// Parallel programming port: loading, command decode, array access
// How it works
// R1: Both arrays read all ones before any programming; reset sweeps them erased.
// R2: A data-memory byte write overwrites the location, erase included in the write.
// R3: Load strobe rising: action 00 address, 01 data, 10 command, 11 nothing.
// R4: Byte-half select picks low or high half for address and program data loads.
// R5: Write or read strobe low performs the operation of the last loaded command.
// R6: Commands 80 chip erase, 40 write fuses, 20 write lock bits.
// R7: Commands 10 write program memory, 11 write data memory.
// R8: Commands 08 read identification bytes, 04 read lock and fuse bits.
// R9: Commands 02 read program memory, 03 read data memory.
// R10: Ready output low while an operation runs, high once it finishes and the port is idle.
// R11: Bus driven only while read strobe is low; programmer drives it otherwise.
// R12: Programmer pulses write strobe low to trigger writes.
// R13: Programmer sets byte-half select 0 for low byte, 1 for high byte.
// R14: Programmer loads commands with action 10, select 0, then a load pulse.
// R15: Programmer waits for ready high before the next byte write.
// R16: Three identification bytes in their own address space, readable here.
// R17: Action code, select and bus value are captured on the load strobe rising edge.
`timescale 1ns/1ps
module ppp_port (
    input wire logic i_mclk, // 50 MHz clock
    input wire logic i_sys_rst, // Synchronous reset, active high
    input wire logic i_load_strobe_pin, // Load strobe, positive pulse
    input wire logic i_strobe_action_bit0, // Action code bit 0
    input wire logic i_strobe_action_bit1, // Action code bit 1
    input wire logic i_byte_half_select, // 0 low half, 1 high half
    input wire logic i_wr_n, // Write strobe, active low
    input wire logic i_oe_n, // Read strobe, active low
    input wire logic [7:0] i_data, // Bus input
    output logic [7:0] o_data, // Bus output
    output logic o_data_oe, // Bus output enable, high drives
    output logic o_ready_not_busy_out // 1 ready, 0 busy
);
    import ppp_pkg::*;

    function automatic logic is_timed_write(input logic [7:0] c);
        is_timed_write = (c == CMD_WR_FLASH) || (c == CMD_WR_EE) ||
                         (c == CMD_WR_FUSE) || (c == CMD_WR_LOCK);
    endfunction

    ppp_state_t state;
    logic load_q;
    logic wr_q;
    logic [15:0] addr;
    logic [7:0] dlo;
    logic [7:0] dhi;
    logic [7:0] cmd;
    logic [7:0] fuse;
    logic [1:0] lock;
    logic [7:0] busy_cnt;
    logic [FLASH_AW-1:0] erase_cnt;
    logic [1:0] act;
    logic load_rise;
    logic wr_fall;
    logic fl_we;
    logic ee_we;
    logic [FLASH_AW-1:0] fl_addr;
    logic [EE_AW-1:0] ee_addr;
    logic [15:0] fl_wdata;
    logic [7:0] ee_wdata;
    logic [15:0] fl_rdata;
    logic [7:0] ee_rdata;

    assign act = {i_strobe_action_bit1, i_strobe_action_bit0};
    assign load_rise = i_load_strobe_pin & ~load_q;
    assign wr_fall = ~i_wr_n & wr_q;

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            load_q <= 1'b0;
            wr_q <= 1'b1;
        end else begin
            load_q <= i_load_strobe_pin;
            wr_q <= i_wr_n;
        end
    end

    // Loading from the bus on the load strobe
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            addr <= 16'h0000;
            dlo <= 8'h00;
            dhi <= 8'h00;
            cmd <= 8'h00;
        end else if (load_rise) begin // [R17]
            case (act) // [R3]
                ACT_ADDR: begin
                    if (i_byte_half_select) begin // [R4]
                        addr[15:8] <= i_data;
                    end else begin
                        addr[7:0] <= i_data;
                    end
                end
                ACT_DATA: begin
                    if (i_byte_half_select) begin // [R4]
                        dhi <= i_data;
                    end else begin
                        dlo <= i_data;
                    end
                end
                ACT_CMD: cmd <= i_data;
                default: ;
            endcase
        end
    end

    // Sequencer: erase sweep, self-timed writes, ready output
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            state <= ST_ERASE; // [R1]
            erase_cnt <= '0;
            busy_cnt <= 8'h00;
            o_ready_not_busy_out <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (wr_fall && cmd == CMD_CHIP_ERASE) begin // [R5] [R6]
                        state <= ST_ERASE;
                        erase_cnt <= '0;
                        o_ready_not_busy_out <= 1'b0; // [R10]
                    end else if (wr_fall && is_timed_write(cmd)) begin // [R5]
                        state <= ST_PROG;
                        busy_cnt <= 8'(PROG_CYCLES - 1);
                        o_ready_not_busy_out <= 1'b0; // [R10]
                    end
                end
                ST_ERASE: begin
                    erase_cnt <= erase_cnt + 1'b1;
                    if (erase_cnt == FLASH_LAST) begin
                        state <= ST_IDLE;
                        o_ready_not_busy_out <= 1'b1; // [R10]
                    end
                end
                ST_PROG: begin
                    busy_cnt <= busy_cnt - 1'b1;
                    if (busy_cnt == 8'h00) begin
                        state <= ST_IDLE;
                        o_ready_not_busy_out <= 1'b1; // [R10]
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    o_ready_not_busy_out <= 1'b1;
                end
            endcase
        end
    end

    // Fuse and lock bits; lock bits return only on reset or after a finished erase
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            fuse <= FUSE_RESET;
            lock <= LOCK_RESET;
        end else if (state == ST_ERASE && erase_cnt == FLASH_LAST) begin
            lock <= LOCK_RESET;
        end else if (state == ST_IDLE && wr_fall) begin
            if (cmd == CMD_WR_FUSE) begin // [R6]
                fuse <= dlo;
            end
            if (cmd == CMD_WR_LOCK) begin // [R6]
                lock <= lock & dlo[LOCK_LSB +: 2];
            end
        end
    end

    always_comb begin
        fl_we = 1'b0;
        ee_we = 1'b0;
        fl_addr = addr[FLASH_AW-1:0];
        ee_addr = addr[EE_AW-1:0];
        fl_wdata = {dhi, dlo};
        ee_wdata = dlo;
        if (state == ST_ERASE) begin // [R1]
            fl_we = 1'b1;
            ee_we = (erase_cnt[FLASH_AW-1:EE_AW] == '0);
            fl_addr = erase_cnt;
            ee_addr = erase_cnt[EE_AW-1:0];
            fl_wdata = ERASED_WORD;
            ee_wdata = ERASED_BYTE;
        end else if (state == ST_IDLE && wr_fall) begin
            fl_we = (cmd == CMD_WR_FLASH); // [R7]
            ee_we = (cmd == CMD_WR_EE); // [R7] [R2]
        end
    end

    ppp_mem #(.AW(FLASH_AW), .DW(16)) u_flash (
        .i_mclk(i_mclk),
        .i_we(fl_we),
        .i_addr(fl_addr),
        .i_wdata(fl_wdata),
        .o_rdata(fl_rdata)
    );

    ppp_mem #(.AW(EE_AW), .DW(8)) u_eeprom (
        .i_mclk(i_mclk),
        .i_we(ee_we),
        .i_addr(ee_addr),
        .i_wdata(ee_wdata),
        .o_rdata(ee_rdata)
    );

    // Read path and bus drive
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_data <= 8'h00;
            o_data_oe <= 1'b0;
        end else begin
            o_data_oe <= ~i_oe_n; // [R11]
            case (cmd) // [R5]
                CMD_RD_SIG: begin // [R8] [R16]
                    case (addr[1:0])
                        2'h0: o_data <= SIG_BYTE0;
                        2'h1: o_data <= SIG_BYTE1;
                        2'h2: o_data <= SIG_BYTE2;
                        default: o_data <= 8'h00;
                    endcase
                end
                CMD_RD_LOCKFUSE: o_data <= {lock, fuse[5:0]}; // [R8]
                CMD_RD_FLASH: begin // [R9]
                    o_data <= i_byte_half_select ? fl_rdata[15:8] : fl_rdata[7:0];
                end
                CMD_RD_EE: o_data <= ee_rdata; // [R9]
                default: o_data <= ERASED_BYTE;
            endcase
        end
    end

    property p_addr_lo;
        @(posedge i_mclk) disable iff (i_sys_rst)
        (load_rise && act == ACT_ADDR && !i_byte_half_select) |=> (addr[7:0] == $past(i_data));
    endproperty
    a_addr_lo: assert property (p_addr_lo) else $error("address low byte not loaded"); // [R3]

    property p_data_hi;
        @(posedge i_mclk) disable iff (i_sys_rst)
        (load_rise && act == ACT_DATA && i_byte_half_select) |=>
            (dhi == $past(i_data) && $stable(dlo));
    endproperty
    a_data_hi: assert property (p_data_hi) else $error("data high byte not loaded"); // [R4]

    property p_idle_act;
        @(posedge i_mclk) disable iff (i_sys_rst)
        (load_rise && act == ACT_IDLE) |=> ($stable(cmd) && $stable(addr) && $stable(dlo));
    endproperty
    a_idle_act: assert property (p_idle_act) else $error("idle action changed state"); // [R3]

    property p_busy_start;
        @(posedge i_mclk) disable iff (i_sys_rst)
        (state == ST_IDLE && wr_fall && cmd == CMD_WR_FLASH) |=>
            (!o_ready_not_busy_out && state == ST_PROG);
    endproperty
    a_busy_start: assert property (p_busy_start) else $error("write did not go busy"); // [R10]

    property p_busy_end;
        @(posedge i_mclk) disable iff (i_sys_rst)
        (state == ST_PROG && busy_cnt == 8'h00) |=> (o_ready_not_busy_out && state == ST_IDLE);
    endproperty
    a_busy_end: assert property (p_busy_end) else $error("ready not restored"); // [R10]

    property p_bus_drive;
        @(posedge i_mclk) disable iff (i_sys_rst)
        1'b1 |=> (o_data_oe == !$past(i_oe_n));
    endproperty
    a_bus_drive: assert property (p_bus_drive) else $error("bus enable wrong"); // [R11]

    property p_rd_ee;
        @(posedge i_mclk) disable iff (i_sys_rst)
        (cmd == CMD_RD_EE) |=> (o_data == $past(ee_rdata));
    endproperty
    a_rd_ee: assert property (p_rd_ee) else $error("data memory read wrong"); // [R9]

    property p_erase_ones;
        @(posedge i_mclk) disable iff (i_sys_rst)
        (state == ST_ERASE) |-> (fl_we && fl_wdata == ERASED_WORD && !o_ready_not_busy_out);
    endproperty
    a_erase_ones: assert property (p_erase_ones) else $error("erase not writing ones"); // [R1]

    property p_lock_wr;
        @(posedge i_mclk) disable iff (i_sys_rst)
        (state == ST_IDLE && wr_fall && cmd == CMD_WR_LOCK) |=>
            (lock == ($past(lock) & $past(dlo[2:1])));
    endproperty
    a_lock_wr: assert property (p_lock_wr) else $error("lock bits not written"); // [R6]

    property p_ee_write;
        @(posedge i_mclk) disable iff (i_sys_rst)
        (state == ST_IDLE && wr_fall && cmd == CMD_WR_EE) |-> (ee_we && !fl_we);
    endproperty
    a_ee_write: assert property (p_ee_write) else $error("data memory write missing"); // [R7]
endmodule

// [ppp_prog_model.sv]
// Programmer model: drives the strobes, action code, select and bus
`timescale 1ns/1ps
module ppp_prog_model (
    input wire logic i_mclk, // Clock
    input wire logic i_data_oe, // Device drives bus
    input wire logic [7:0] i_dev_data, // Device bus value
    output logic o_strobe, // Load strobe
    output logic [1:0] o_act, // Action code
    output logic o_byte_half_select, // Byte-half select
    output logic o_wr_n, // Write strobe
    output logic o_oe_n, // Read strobe
    output logic [7:0] o_bus // Resolved bus wire
);
    logic [7:0] drv = 8'h00;
    assign o_bus = i_data_oe ? i_dev_data : drv;
    initial begin
        o_strobe = 1'b0;
        o_act = 2'h3;
        o_byte_half_select = 1'b0;
        o_wr_n = 1'b1;
        o_oe_n = 1'b1;
    end
    task automatic load(input logic [1:0] act, input logic sel, input logic [7:0] d);
        @(posedge i_mclk);
        o_act <= act;
        o_byte_half_select <= sel;
        drv <= d;
        @(posedge i_mclk);
        o_strobe <= 1'b1;
        @(posedge i_mclk);
        o_strobe <= 1'b0;
    endtask
    task automatic write_pulse();
        @(posedge i_mclk);
        o_wr_n <= 1'b0;
        @(posedge i_mclk);
        o_wr_n <= 1'b1;
    endtask
    task automatic read(input logic sel, output logic [7:0] d, output logic oe);
        @(posedge i_mclk);
        o_byte_half_select <= sel;
        o_oe_n <= 1'b0;
        drv <= ~drv; // Released bus must not keep a stale value
        repeat (2) @(posedge i_mclk);
        #1;
        // Take the resolved bus, so a missing drive shows as wrong data
        d = o_bus;
        oe = i_data_oe;
        @(posedge i_mclk);
        o_oe_n <= 1'b1;
    endtask
endmodule

// [parallel_program_port_tb_top.sv]
// Self-checking testbench for the parallel program port
`timescale 1ns/1ps
module parallel_program_port_tb_top;
    import ppp_pkg::*;
    logic i_mclk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic strobe, byte_half_select, wr_n, oe_n, data_oe, ready;
    logic [1:0] act;
    logic [7:0] bus, dev_data;
    int bad_count = 0;
    int total_checks = 0;
    always #10 i_mclk = ~i_mclk;
    ppp_port dut (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_load_strobe_pin(strobe),
        .i_strobe_action_bit0(act[0]), .i_strobe_action_bit1(act[1]),
        .i_byte_half_select(byte_half_select), .i_wr_n(wr_n), .i_oe_n(oe_n), .i_data(bus),
        .o_data(dev_data), .o_data_oe(data_oe), .o_ready_not_busy_out(ready));
    ppp_prog_model prog (.i_mclk(i_mclk), .i_data_oe(data_oe), .i_dev_data(dev_data),
        .o_strobe(strobe), .o_act(act), .o_byte_half_select(byte_half_select),
        .o_wr_n(wr_n), .o_oe_n(oe_n),
        .o_bus(bus));
    task automatic report_and_stop();
        if (bad_count == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wait_ready(input int limit, output int n);
        n = 0;
        while (ready !== 1'b1) begin
            if (n == limit) begin
                bad_count++;
                $display("mismatch at %0t: ready timeout", $time);
                report_and_stop();
            end
            @(posedge i_mclk);
            #1;
            n++;
        end
    endtask
    task automatic cmd(input logic [7:0] c);
        prog.load(ACT_CMD, 1'b0, c);
    endtask
    task automatic addr(input logic [15:0] a);
        prog.load(ACT_ADDR, 1'b0, a[7:0]);
        prog.load(ACT_ADDR, 1'b1, a[15:8]);
    endtask
    task automatic do_write(input int min_busy);
        int n;
        prog.write_pulse();
        @(posedge i_mclk);
        #1;
        chk({7'h0, ready}, 8'h00);
        wait_ready(min_busy + 200, n);
        chk({7'h0, n >= min_busy}, 8'h01);
    endtask
    task automatic rd_chk(input logic sel, input logic [7:0] exp);
        logic [7:0] d;
        logic oe;
        prog.read(sel, d, oe);
        chk(d, exp);
        chk({7'h0, oe}, 8'h01);
        repeat (2) @(posedge i_mclk);
        #1;
        chk({7'h0, data_oe}, 8'h00);
    endtask
    task automatic t_erased();
        cmd(CMD_RD_FLASH);
        addr(16'h0a5c);
        rd_chk(1'b0, ERASED_BYTE);
        rd_chk(1'b1, ERASED_BYTE);
        cmd(CMD_RD_EE);
        addr(16'h01f3);
        rd_chk(1'b0, ERASED_BYTE);
    endtask
    task automatic t_flash();
        cmd(CMD_WR_FLASH);
        addr(16'h0a5c);
        prog.load(ACT_DATA, 1'b0, 8'h34);
        prog.load(ACT_DATA, 1'b1, 8'h12);
        prog.load(ACT_IDLE, 1'b0, 8'h77);
        do_write(PROG_CYCLES - 10);
        cmd(CMD_RD_FLASH);
        rd_chk(1'b0, 8'h34);
        rd_chk(1'b1, 8'h12);
    endtask
    task automatic t_eeprom();
        cmd(CMD_WR_EE);
        addr(16'h01f3);
        prog.load(ACT_DATA, 1'b0, 8'h0f);
        do_write(PROG_CYCLES - 10);
        prog.load(ACT_DATA, 1'b0, 8'hf0);
        do_write(PROG_CYCLES - 10);
        cmd(CMD_RD_EE);
        rd_chk(1'b0, 8'hf0);
    endtask
    task automatic t_signature();
        logic [7:0] sig [4];
        sig = '{SIG_BYTE0, SIG_BYTE1, SIG_BYTE2, 8'h00};
        cmd(CMD_RD_SIG);
        for (int i = 0; i < 4; i++) begin
            prog.load(ACT_ADDR, 1'b0, 8'(i));
            rd_chk(1'b0, sig[i]);
        end
    endtask
    task automatic t_lock_fuse_erase();
        cmd(CMD_WR_FUSE);
        prog.load(ACT_DATA, 1'b0, 8'h2a);
        do_write(PROG_CYCLES - 10);
        cmd(CMD_WR_LOCK);
        prog.load(ACT_DATA, 1'b0, 8'h00);
        do_write(PROG_CYCLES - 10);
        cmd(CMD_RD_LOCKFUSE);
        rd_chk(1'b0, 8'h2a);
        cmd(CMD_CHIP_ERASE);
        do_write(4000);
        cmd(CMD_RD_LOCKFUSE);
        rd_chk(1'b0, 8'hea);
        cmd(CMD_RD_FLASH);
        addr(16'h0a5c);
        rd_chk(1'b1, ERASED_BYTE);
    endtask
    initial begin
        int n;
        repeat (2) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        @(posedge i_mclk);
        #1;
        chk({7'h0, ready}, 8'h00);
        chk({7'h0, data_oe}, 8'h00);
        wait_ready(5000, n);
        t_erased();
        t_flash();
        t_eeprom();
        t_signature();
        t_lock_fuse_erase();
        report_and_stop();
    end
endmodule
